// ==== core/sbss_pkg.sv ====
// Shared constants and types for the burst SRAM select and sleep ends
package sbss_pkg;

	// ==========================================================
	// Bus shape
	localparam int ADDR_W = 19;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	localparam int STORE_AW_DEF = 4;

	// ==========================================================
	// Sleep timing, in clock cycles
	localparam int SLEEP_ENTRY_CYCLES = 2;
	localparam int SLEEP_EXIT_CYCLES = 2;
	localparam logic [1:0] WAKE_LOAD = 2'(SLEEP_EXIT_CYCLES - 1);

	// ==========================================================
	// Read pipeline: edges from strobe sample to data on the bus
	localparam int READ_LATENCY = 2;
	localparam logic [1:0] READ_LOAD = 2'(READ_LATENCY);

	// ==========================================================
	// Controller states
	typedef enum logic [1:0] {
		CTL_IDLE,
		CTL_READ,
		CTL_SLEEP,
		CTL_WAKE
	} sbss_ctl_state_t;

endpackage

// ==== core/sbss_bus_if.sv ====
// Pin-level bus between the memory controller and the burst SRAM
interface sbss_bus_if #(
	parameter int ADDR_W = sbss_pkg::ADDR_W,
	parameter int LANES = sbss_pkg::LANES,
	parameter int LANE_W = sbss_pkg::LANE_W
);
	logic sleep_request;
	logic processor_address_strobe_n;
	logic controller_address_strobe_n;
	logic global_write_n;
	logic byte_write_enable_n;
	logic [LANES-1:0] lane_write_strobe_n;
	logic first_select_n;
	logic high_active_select;
	logic second_select_n;
	logic [ADDR_W-1:0] addr;
	logic [LANES*LANE_W-1:0] dq_from_ctrl;
	logic dq_ctrl_oe;
	logic [LANES*LANE_W-1:0] dq_from_sram;
	logic dq_sram_oe;

	modport sram (
		input sleep_request, processor_address_strobe_n, controller_address_strobe_n,
		input global_write_n, byte_write_enable_n, lane_write_strobe_n,
		input first_select_n, high_active_select, second_select_n, addr,
		input dq_from_ctrl, dq_ctrl_oe,
		output dq_from_sram, dq_sram_oe
	);

	modport ctrl (
		output sleep_request, processor_address_strobe_n, controller_address_strobe_n,
		output global_write_n, byte_write_enable_n, lane_write_strobe_n,
		output first_select_n, high_active_select, second_select_n, addr,
		output dq_from_ctrl, dq_ctrl_oe,
		input dq_from_sram, dq_sram_oe
	);
endinterface

// ==== core/sbss_ctrl.sv ====
// Memory controller end: issues accesses and sequences sleep entry and exit
module sbss_ctrl #(
	parameter bit EXPAND = 1'b0
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// Pin bus
	sbss_bus_if.ctrl bus,
	// Access requests
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic [sbss_pkg::ADDR_W-1:0] i_req_addr,
	input wire logic [sbss_pkg::DATA_W-1:0] i_req_wdata,
	input wire logic [sbss_pkg::LANES-1:0] i_req_lanes,
	input wire logic i_req_all_lanes,
	output logic o_req_ready,
	// Read answers
	output logic o_rsp_valid,
	output logic [sbss_pkg::DATA_W-1:0] o_rsp_rdata,
	// Sleep control
	input wire logic i_sleep,
	output logic o_sleep_active
);
	import sbss_pkg::*;

	sbss_ctl_state_t state, next_state;
	logic [1:0] count, next_count;
	logic sleep_req, next_sleep_req;
	logic strobe_n, next_strobe_n;
	logic gw_n, next_gw_n;
	logic bwe_n, next_bwe_n;
	logic [LANES-1:0] lane_n, next_lane_n;
	logic sel1_n, next_sel1_n;
	logic sel_hi, next_sel_hi;
	logic sel2_n, next_sel2_n;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [DATA_W-1:0] wdata, next_wdata;
	logic drive, next_drive;
	logic rsp_valid, next_rsp_valid;
	logic [DATA_W-1:0] rdata, next_rdata;
	logic take;

	// ==========================================================
	// Sequencing
	assign o_req_ready = (state == CTL_IDLE) && !i_sleep;
	assign take = o_req_ready && i_req_valid;

	always_comb begin
		next_state = state;
		next_count = count;
		next_sleep_req = sleep_req;
		next_strobe_n = 1'b1;
		next_gw_n = 1'b1;
		next_bwe_n = 1'b1;
		next_lane_n = '1;
		next_sel1_n = 1'b1;
		next_sel_hi = sel_hi;
		next_sel2_n = sel2_n;
		next_addr = addr;
		next_wdata = wdata;
		next_drive = 1'b0;
		next_rsp_valid = 1'b0;
		next_rdata = rdata;
		case (state)
			CTL_IDLE: begin
				// Sleep is raised only from idle, so no read is in flight
				if (i_sleep) begin
					next_sleep_req = 1'b1;
					next_state = CTL_SLEEP;
				end else if (take) begin
					next_strobe_n = 1'b0;
					next_sel1_n = 1'b0;
					next_sel_hi = EXPAND ? i_req_addr[ADDR_W-1] : 1'b1;
					next_sel2_n = EXPAND ? i_req_addr[ADDR_W-1] : 1'b0;
					next_addr = i_req_addr;
					if (i_req_write) begin
						next_gw_n = !i_req_all_lanes;
						next_bwe_n = i_req_all_lanes;
						next_lane_n = ~i_req_lanes;
						next_wdata = i_req_wdata;
						next_drive = 1'b1;
					end else begin
						next_count = READ_LOAD;
						next_state = CTL_READ;
					end
				end
			end
			CTL_READ: begin
				if (count == 2'h0) begin
					next_rsp_valid = 1'b1;
					next_rdata = bus.dq_from_sram;
					next_state = CTL_IDLE;
				end else begin
					next_count = count - 2'h1;
				end
			end
			CTL_SLEEP: begin
				if (!i_sleep) begin
					next_sleep_req = 1'b0;
					next_count = WAKE_LOAD;
					next_state = CTL_WAKE;
				end
			end
			CTL_WAKE: begin
				// Strobes stay high through the exit window; nothing is issued
				if (count == 2'h0) begin
					next_state = CTL_IDLE;
				end else begin
					next_count = count - 2'h1;
				end
			end
			default: begin
				next_state = CTL_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= CTL_IDLE;
			count <= 2'h0;
			sleep_req <= 1'b0;
			strobe_n <= 1'b1;
			gw_n <= 1'b1;
			bwe_n <= 1'b1;
			lane_n <= '1;
			sel1_n <= 1'b1;
			sel_hi <= 1'b1;
			sel2_n <= 1'b0;
			addr <= '0;
			wdata <= '0;
			drive <= 1'b0;
			rsp_valid <= 1'b0;
			rdata <= '0;
		end else begin
			state <= next_state;
			count <= next_count;
			sleep_req <= next_sleep_req;
			strobe_n <= next_strobe_n;
			gw_n <= next_gw_n;
			bwe_n <= next_bwe_n;
			lane_n <= next_lane_n;
			sel1_n <= next_sel1_n;
			sel_hi <= next_sel_hi;
			sel2_n <= next_sel2_n;
			addr <= next_addr;
			wdata <= next_wdata;
			drive <= next_drive;
			rsp_valid <= next_rsp_valid;
			rdata <= next_rdata;
		end
	end

	// ==========================================================
	// Pin drive; the processor strobe is unused by this controller
	assign bus.sleep_request = sleep_req;
	assign bus.processor_address_strobe_n = 1'b1;
	assign bus.controller_address_strobe_n = strobe_n;
	assign bus.global_write_n = gw_n;
	assign bus.byte_write_enable_n = bwe_n;
	assign bus.lane_write_strobe_n = lane_n;
	assign bus.first_select_n = sel1_n;
	assign bus.high_active_select = sel_hi;
	assign bus.second_select_n = sel2_n;
	assign bus.addr = addr;
	assign bus.dq_from_ctrl = wdata;
	assign bus.dq_ctrl_oe = drive;

	assign o_rsp_valid = rsp_valid;
	assign o_rsp_rdata = rdata;
	assign o_sleep_active = sleep_req;
endmodule

// ==== core/sbss_sram.sv ====
// Burst SRAM end: chip select decode, write qualify, address capture, sleep
module sbss_sram #(
	parameter int STORE_AW = sbss_pkg::STORE_AW_DEF
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// Pin bus
	sbss_bus_if.sram bus,
	// Status
	output logic o_asleep,
	output logic o_enabled,
	output logic o_addr_taken,
	output logic o_write_taken,
	output logic [sbss_pkg::ADDR_W-1:0] o_taken_addr
);
	import sbss_pkg::*;

	// ==========================================================
	// Sleep request synchroniser
	// The pin is asynchronous, so it crosses two flops; that pair is what
	// sets the two-cycle entry and exit windows.
	// Reset clears both flops, so the device always leaves reset awake.
	logic sleep_meta, next_sleep_meta;
	logic sleep_sync, next_sleep_sync;
	logic asleep;

	always_comb begin
		next_sleep_meta = bus.sleep_request;
		next_sleep_sync = sleep_meta;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sleep_meta <= 1'b0;
			sleep_sync <= 1'b0;
		end else begin
			sleep_meta <= next_sleep_meta;
			sleep_sync <= next_sleep_sync;
		end
	end

	assign asleep = sleep_sync;

	// ==========================================================
	// Select decode
	// Sleep masks both strobes here, so nothing downstream can start an
	// access while the device is asleep.
	logic selected;
	logic proc_strobe;
	logic ctrl_strobe;
	logic strobe;
	logic access;

	always_comb begin
		selected = !bus.first_select_n && bus.high_active_select
			&& !bus.second_select_n;
		// First select high blocks the processor strobe, so a cycle meant
		// for another device on the shared bus cannot start one here
		proc_strobe = !asleep && !bus.processor_address_strobe_n
			&& !bus.first_select_n;
		ctrl_strobe = !asleep && !bus.controller_address_strobe_n;
		strobe = proc_strobe || ctrl_strobe;
		access = strobe && selected;
	end

	// ==========================================================
	// Write qualify
	// Global write covers every lane and overrides the byte enables; lane
	// strobes count only while the byte enable is low, and with neither
	// asserted the cycle is a read.
	logic is_write;
	logic [LANES-1:0] lane_wr;
	logic [STORE_AW-1:0] index;

	always_comb begin
		if (!bus.global_write_n) begin
			lane_wr = '1;
		end else if (!bus.byte_write_enable_n) begin
			lane_wr = ~bus.lane_write_strobe_n;
		end else begin
			lane_wr = '0;
		end
		is_write = |lane_wr;
		index = bus.addr[STORE_AW-1:0];
	end

	// ==========================================================
	// Storage array, flops indexed by the low address bits
	// No reset: contents stay undefined until written, which keeps the array
	// out of the reset tree. Write data is taken on the strobe edge itself.
	logic [DATA_W-1:0] mem [2**STORE_AW];
	logic [DATA_W-1:0] next_mem [2**STORE_AW];
	logic [DATA_W-1:0] next_word;

	always_comb begin
		// Lanes left out of the write keep their stored data
		next_word = mem[index];
		for (int l = 0; l < LANES; l++) begin
			if (lane_wr[l]) begin
				next_word[l*LANE_W +: LANE_W] = bus.dq_from_ctrl[l*LANE_W +: LANE_W];
			end
		end
		next_mem = mem;
		if (access && is_write) begin
			next_mem[index] = next_word;
		end
	end

	always_ff @(posedge i_core_clk) begin
		mem <= next_mem;
	end

	// ==========================================================
	// Enable and address capture
	logic enabled, next_enabled;
	logic [ADDR_W-1:0] taken_addr, next_taken_addr;
	logic addr_taken, next_addr_taken;
	logic write_taken, next_write_taken;

	always_comb begin
		next_enabled = enabled;
		if (asleep) begin
			// Sleep wins: a strobe cannot re-enable a sleeping device
			next_enabled = 1'b0;
		end else if (strobe) begin
			// A strobe seen without full select drops the device out
			next_enabled = selected;
		end
		// The captured address holds until the next selected strobe
		next_taken_addr = access ? bus.addr : taken_addr;
		// Status pulses last one cycle each
		next_addr_taken = access;
		next_write_taken = access && is_write;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			enabled <= 1'b0;
			taken_addr <= '0;
			addr_taken <= 1'b0;
			write_taken <= 1'b0;
		end else begin
			enabled <= next_enabled;
			taken_addr <= next_taken_addr;
			addr_taken <= next_addr_taken;
			write_taken <= next_write_taken;
		end
	end

	// ==========================================================
	// Read pipeline: two register stages from strobe to bus
	// Anything in flight when sleep lands is dropped rather than finished,
	// which is why the controller drains reads before it raises sleep.
	// Read data stands one cycle; the controller samples it at the next edge.
	logic rd1_valid, next_rd1_valid;
	logic rd2_valid, next_rd2_valid;
	logic [DATA_W-1:0] rd1_data, next_rd1_data;
	logic [DATA_W-1:0] rd2_data, next_rd2_data;

	always_comb begin
		next_rd1_valid = access && !is_write;
		next_rd1_data = mem[index];
		next_rd2_valid = rd1_valid && !asleep;
		next_rd2_data = rd1_data;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rd1_valid <= 1'b0;
			rd2_valid <= 1'b0;
			rd1_data <= '0;
			rd2_data <= '0;
		end else begin
			rd1_valid <= next_rd1_valid;
			rd2_valid <= next_rd2_valid;
			rd1_data <= next_rd1_data;
			rd2_data <= next_rd2_data;
		end
	end

	// ==========================================================
	// Outputs
	// Only the data bus floats while asleep; the status outputs are local
	// to the system and stay readable.
	assign bus.dq_from_sram = rd2_data;
	assign bus.dq_sram_oe = rd2_valid && !asleep;
	assign o_asleep = asleep;
	assign o_enabled = enabled;
	assign o_addr_taken = addr_taken;
	assign o_write_taken = write_taken;
	assign o_taken_addr = taken_addr;
endmodule

// ==== dv/sbss_monitor.sv ====
// Pin bus assertions for the controller to SRAM link
module sbss_monitor (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// Pin bus
	input wire logic sleep_request,
	input wire logic processor_address_strobe_n,
	input wire logic controller_address_strobe_n,
	input wire logic global_write_n,
	input wire logic byte_write_enable_n,
	input wire logic [sbss_pkg::LANES-1:0] lane_write_strobe_n,
	input wire logic first_select_n,
	input wire logic high_active_select,
	input wire logic second_select_n,
	input wire logic [sbss_pkg::ADDR_W-1:0] addr,
	input wire logic dq_sram_oe,
	// SRAM status
	input wire logic o_asleep,
	input wire logic o_addr_taken,
	input wire logic o_write_taken,
	input wire logic [sbss_pkg::ADDR_W-1:0] o_taken_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	import sbss_pkg::*;
	logic sel;
	logic stb;
	logic wr;
	// Processor strobe counts only with the first select low
	assign sel = !first_select_n && high_active_select && !second_select_n;
	assign stb = !controller_address_strobe_n || (!processor_address_strobe_n && !first_select_n);
	assign wr = !global_write_n || (!byte_write_enable_n && !(&lane_write_strobe_n));
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);

	// ==========================================================
	// Sleep
	property p_asleep_track;
		o_asleep == $past(sleep_request, 2);
	endproperty
	a_asleep_track: assert property (p_asleep_track) else $error("asleep lag wrong");
	property p_hiz;
		o_asleep |-> !dq_sram_oe;
	endproperty
	a_hiz: assert property (p_hiz) else $error("sram drives while asleep");
	property p_exit_quiet;
		$fell(sleep_request) |-> (controller_address_strobe_n && processor_address_strobe_n) [*3];
	endproperty
	a_exit_quiet: assert property (p_exit_quiet) else $error("strobe in exit window");
	property p_sleep_quiet;
		sleep_request |-> controller_address_strobe_n;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("strobe during sleep");

	// ==========================================================
	// Select, capture and write
	property p_select;
		stb |-> sel;
	endproperty
	a_select: assert property (p_select) else $error("strobe without select");
	property p_capture;
		stb && sel && !o_asleep |=> o_addr_taken && o_taken_addr == $past(addr);
	endproperty
	a_capture: assert property (p_capture) else $error("address not captured");
	property p_write;
		stb && sel && !o_asleep && wr |=> o_write_taken;
	endproperty
	a_write: assert property (p_write) else $error("write not taken");
	property p_no_write;
		stb && !wr |=> !o_write_taken;
	endproperty
	a_no_write: assert property (p_no_write) else $error("spurious write");
endmodule

// ==== dv/tb.sv ====
// Bench joining the controller and SRAM ends, plus one bench-driven SRAM
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sbss_pkg::*;
	logic i_core_clk;
	logic i_rstn;
	logic i_req_valid;
	logic i_req_write;
	logic [ADDR_W-1:0] i_req_addr;
	logic [DATA_W-1:0] i_req_wdata;
	logic [LANES-1:0] i_req_lanes;
	logic i_req_all_lanes;
	logic o_req_ready;
	logic o_rsp_valid;
	logic [DATA_W-1:0] o_rsp_rdata;
	logic i_sleep;
	logic o_asleep;
	logic o_addr_taken;
	logic o_write_taken;
	logic [ADDR_W-1:0] o_taken_addr;
	logic o_enabled;
	logic o_sleep_active;
	logic taken_b;
	logic [DATA_W-1:0] mem [16];
	int n_mismatch = 0;
	int tests_run = 0;

	sbss_bus_if bus ();
	sbss_bus_if bus_b ();
	sbss_bus_if bus_x ();
	sbss_ctrl i_sbss_ctrl (.i_core_clk, .i_rstn, .bus(bus.ctrl), .i_req_valid, .i_req_write,
		.i_req_addr, .i_req_wdata, .i_req_lanes, .i_req_all_lanes, .o_req_ready, .o_rsp_valid,
		.o_rsp_rdata, .i_sleep, .o_sleep_active);
	// Expansion controller shadows every request; its high-active and second selects follow the top address bit
	sbss_ctrl #(.EXPAND(1'b1)) i_sbss_ctrl_x (.i_core_clk, .i_rstn, .bus(bus_x.ctrl),
		.i_req_valid, .i_req_write, .i_req_addr, .i_req_wdata, .i_req_lanes, .i_req_all_lanes,
		.o_req_ready(), .o_rsp_valid(), .o_rsp_rdata(), .i_sleep, .o_sleep_active());
	sbss_sram i_sbss_sram (.i_core_clk, .i_rstn, .bus(bus.sram), .o_asleep, .o_enabled,
		.o_addr_taken, .o_write_taken, .o_taken_addr);
	// Second SRAM lets the bench break select rules the controller never breaks
	sbss_sram i_sbss_sram_b (.i_core_clk, .i_rstn, .bus(bus_b.sram), .o_asleep(), .o_enabled(),
		.o_addr_taken(taken_b), .o_write_taken(), .o_taken_addr());
	sbss_monitor i_sbss_monitor (.i_core_clk, .i_rstn, .sleep_request(bus.sleep_request),
		.processor_address_strobe_n(bus.processor_address_strobe_n),
		.controller_address_strobe_n(bus.controller_address_strobe_n),
		.global_write_n(bus.global_write_n), .byte_write_enable_n(bus.byte_write_enable_n),
		.lane_write_strobe_n(bus.lane_write_strobe_n), .first_select_n(bus.first_select_n),
		.high_active_select(bus.high_active_select), .second_select_n(bus.second_select_n),
		.addr(bus.addr), .dq_sram_oe(bus.dq_sram_oe), .o_asleep, .o_addr_taken,
		.o_write_taken, .o_taken_addr);

	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	// ==========================================================
	// Tasks
	task automatic test_done(input bit hung);
		if (hung) begin
			n_mismatch++;
			$display("mismatch t=%0t timeout", $time);
		end
		if (n_mismatch == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wait_ready();
		for (int k = 0; k < 50 && o_req_ready !== 1'b1; k++)
			@(negedge i_core_clk);
		if (o_req_ready !== 1'b1)
			test_done(1'b1);
	endtask

	// Leaves the request up so writes can run back to back
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
			input logic [LANES-1:0] l, input logic all);
		wait_ready();
		{i_req_valid, i_req_write, i_req_addr, i_req_wdata} = {2'b11, a, d};
		{i_req_lanes, i_req_all_lanes} = {l, all};
		for (int j = 0; j < LANES; j++)
			if (all || l[j])
				mem[a[3:0]][j*LANE_W +: LANE_W] = d[j*LANE_W +: LANE_W];
		@(negedge i_core_clk);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		wait_ready();
		{i_req_valid, i_req_write, i_req_addr} = {2'b10, a};
		@(negedge i_core_clk);
		i_req_valid = 1'b0;
		for (int k = 0; k < 20 && o_rsp_valid !== 1'b1; k++)
			@(negedge i_core_clk);
		if (o_rsp_valid !== 1'b1)
			test_done(1'b1);
		chk(o_rsp_rdata, mem[a[3:0]]);
	endtask

	task automatic sel_try(input logic [2:0] cs, input logic exp);
		{bus_b.first_select_n, bus_b.high_active_select, bus_b.second_select_n} = cs;
		bus_b.controller_address_strobe_n = 1'b0;
		@(negedge i_core_clk);
		chk(taken_b, exp);
		bus_b.controller_address_strobe_n = 1'b1;
		@(negedge i_core_clk);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{i_rstn, i_sleep, i_req_valid, i_req_write, i_req_all_lanes} = 5'h00;
		{i_req_addr, i_req_wdata, i_req_lanes} = '0;
		{bus_b.sleep_request, bus_b.processor_address_strobe_n} = 2'b01;
		{bus_b.controller_address_strobe_n, bus_b.global_write_n} = 2'b11;
		{bus_b.byte_write_enable_n, bus_b.lane_write_strobe_n} = 5'h1f;
		{bus_b.first_select_n, bus_b.high_active_select, bus_b.second_select_n} = 3'h5;
		{bus_b.addr, bus_b.dq_from_ctrl, bus_b.dq_ctrl_oe} = '0;
		{bus_x.dq_from_sram, bus_x.dq_sram_oe} = '0;
		repeat (16) @(negedge i_core_clk);
		i_rstn = 1'b1;
		@(negedge i_core_clk);
		for (int l = 0; l < LANES; l++) begin
			wr(ADDR_W'(l + 2), 36'h1_2345_6789, 4'h0, 1'b1);
			wr(ADDR_W'(l + 2), 36'hf_edcb_a987, 4'(1 << l), 1'b0);
		end
		wr(19'h4_0006, 36'h5_a5a5_a5a5, 4'h0, 1'b1);
		chk({bus_x.high_active_select, bus_x.second_select_n}, 2'b11);
		chk({bus.high_active_select, bus.second_select_n}, 2'b10);
		wr(19'h0_0002, 36'h0_0000_0000, 4'h0, 1'b0);
		chk({bus_x.high_active_select, bus_x.second_select_n}, 2'b00);
		for (int l = 2; l < 6; l++)
			rd(ADDR_W'(l));
		chk(o_enabled, 1);
		// Sleep while idle, then read straight away on wake
		i_sleep = 1'b1;
		repeat (3) @(negedge i_core_clk);
		chk(o_asleep, 1);
		chk(bus.dq_sram_oe, 0);
		chk(o_req_ready, 0);
		chk(o_sleep_active, 1);
		repeat (5) @(negedge i_core_clk);
		chk(o_asleep, 1);
		chk(o_enabled, 0);
		i_sleep = 1'b0;
		rd(19'h0_0003);
		chk(o_asleep, 0);
		chk(o_enabled, 1);
		chk(o_sleep_active, 0);
		for (int c = 0; c < 8; c++)
			sel_try(3'(c), 1'(c == 2));
		bus_b.sleep_request = 1'b1;
		repeat (3) @(negedge i_core_clk);
		sel_try(3'h2, 1'b0);
		bus_b.sleep_request = 1'b0;
		repeat (3) @(negedge i_core_clk);
		sel_try(3'h2, 1'b1);
		test_done(1'b0);
	end
endmodule
